// ### bench/dcm_ee_model.sv
// Purpose: behavioural configuration eeprom answering the mode fetch
// Assumes: one fetch per reset, request held until the byte is taken
// Notes:   released data lines show the inverse byte, never a stale copy
`timescale 1ns/1ps
module dcm_ee_model
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       eeReq,
  input  wire logic [7:0] cfgByte,
  input  wire logic [7:0] ackDelay,
  output logic            eeAckIn,
  output logic [7:0]      eeDataIn
);
  logic [7:0] waitCnt;

  // ----------------------------------------------------------------------
  // fetch answer
  // ----------------------------------------------------------------------
  // ack after a programmable wait so both prompt and slow parts are seen
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      waitCnt  <= 8'h00;
      eeAckIn  <= 1'b0;
      eeDataIn <= ~cfgByte;
    end
    else if (!eeAckIn && eeReq)
    begin
      waitCnt <= waitCnt + 8'h01;
      if (waitCnt >= ackDelay)
      begin
        eeAckIn  <= 1'b1;
        eeDataIn <= cfgByte;
      end
    end
    else if (eeAckIn && !eeReq)
    begin
      eeAckIn  <= 1'b0;
      eeDataIn <= ~cfgByte; // released lines must not look valid
    end
  end
endmodule : dcm_ee_model

// ### bench/tb_top.sv
// Purpose: self-checking bench of the channel mode selector
// Assumes: eeprom model on the fetch link, bench acts as bus master
// Notes:   read expectations queue up and a monitor compares them
`timescale 1ns/1ps
`include "dcm_regs.svh"
module tb_top;
  import dcm_pkg::*;
  logic        clk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q, expV;
  logic        eeReq, eeAckIn, chbTrafficIn, bufShareA, chbAvailable;
  logic [7:0]  eeDataIn, cfgByte, ackDelay, chbDataOut, chbDataOeN, cfg;
  logic        chbPullUpEn, tx_space_flag_n, rx_data_flag_n, chbStrobeOeN;
  logic [11:0] chbPins;
  dcm_mode_e   modeA, modeB;
  logic [15:0] seed;
  logic [31:0] expQ[$];
  int          miscompares, checks;

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  dcm_mode_select dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .eeReq(eeReq), .eeAckIn(eeAckIn),
    .eeDataIn(eeDataIn), .chbTrafficIn(chbTrafficIn), .modeA(modeA), .modeB(modeB),
    .bufShareA(bufShareA), .chbAvailable(chbAvailable), .chbDataOut(chbDataOut),
    .chbDataOeN(chbDataOeN), .chbPullUpEn(chbPullUpEn), .tx_space_flag_n(tx_space_flag_n),
    .rx_data_flag_n(rx_data_flag_n), .chbStrobeOeN(chbStrobeOeN));

  dcm_ee_model ee (.clk(clk), .sys_rst(sys_rst), .eeReq(eeReq), .cfgByte(cfgByte),
    .ackDelay(ackDelay), .eeAckIn(eeAckIn), .eeDataIn(eeDataIn));

  // channel B pin state gathered for one compare
  assign chbPins = {chbDataOeN, chbPullUpEn, tx_space_flag_n, rx_data_flag_n, chbStrobeOeN};

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic complete_run;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  // one bus cycle; a hang past the bound ends the run
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 300);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 300)
    begin
      miscompares++;
      complete_run();
    end
  endtask : bus

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    expQ.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic cmd(input logic [8:0] c);
    bus(1'b1, `DCM_OFS_CMD, {23'h0, c});
    @(posedge clk);
    #1;
  endtask : cmd

  // reset, optional channel B traffic, then wait for the fetch to finish
  task automatic boot(input logic [7:0] c, input logic [7:0] d, input logic t);
    int n;
    @(posedge clk);
    sys_rst  <= 1'b1;
    cfgByte  <= c;
    ackDelay <= d;
    repeat (2) @(posedge clk);
    sys_rst      <= 1'b0;
    chbTrafficIn <= t;
    @(posedge clk);
    chbTrafficIn <= 1'b0;
    #1;
    chk({modeB, modeA}, {MODE_ASYNC_SERIAL, MODE_ASYNC_SERIAL});
    for (n = 0; n < 100 && eeReq !== 1'b0; n++) @(posedge clk);
    if (n >= 100)
    begin
      miscompares++;
      complete_run();
    end
    repeat (3) @(posedge clk);
    #1;
  endtask : boot

  // ----------------------------------------------------------------------
  // read data monitor
  // ----------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && expQ.size() > 0)
    begin
      expV = expQ.pop_front();
      chk(avs_readdata, expV);
    end
  end

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  initial
  begin
    static logic [8:0] cmdTab [5] = '{9'h001, 9'h004, 9'h002, 9'h000, 9'h101};
    static logic [5:0] modeTab[5] = '{6'h1c, 6'h1d, 6'h1e, 6'h18, 6'h20};
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    chbTrafficIn = 1'b0;
    cfgByte = 8'h00;
    ackDelay = 8'h03;
    seed = 16'h79db;
    miscompares = 0;
    checks = 0;
    @(posedge clk);
    #1;
    chk({modeB, modeA}, {MODE_ASYNC_SERIAL, MODE_ASYNC_SERIAL});
    chk(chbPins, 12'hffb);
    // every eeprom field code on both channels, prompt and slow eeprom
    for (int k = 0; k < 4; k++)
    begin
      cfg = {4'ha, ~k[1:0], k[1:0]};
      boot(cfg, 8'(3 + 4 * k), 1'b0);
      chk(modeA, k);
      chk(modeB, 3 - k);
      rd(`DCM_OFS_EECFG, {24'h0, cfg});
      if (k == 0)
      begin
        for (int i = 0; i < 5; i++)
        begin
          cmd(cmdTab[i]);
          chk({modeB, modeA}, modeTab[i]);
          rd(`DCM_OFS_CMD, {23'h0, cmdTab[i]});
        end
        cmd(9'h008);
        cmd(9'h040);
        chk(modeA, MODE_ASYNC_SERIAL);
        rd(`DCM_OFS_STATUS, 32'h0b40);
        bus(1'b1, `DCM_OFS_STATUS, 32'h200);
        rd(`DCM_OFS_STATUS, 32'h0940);
      end
      if (k == 1)
      begin
        cmd(9'h040);
        chk(modeA, MODE_ASYNC_FIFO);
        rd(`DCM_OFS_STATUS, 32'h0b21);
      end
    end
    // both channels async fifo, channel B idle: sync fifo is granted
    boot(8'h05, 8'h06, 1'b0);
    bus(1'b1, `DCM_OFS_PINSET, 32'h0);
    cmd(9'h040);
    chk(modeA, MODE_SYNC_FIFO);
    chk({bufShareA, chbAvailable}, 2'b10);
    chk(chbPins, 12'hffb);
    cmd(9'h101);
    chk(modeB, MODE_ASYNC_FIFO);
    rd(`DCM_OFS_STATUS, 32'h0f17);
    cmd(9'h000);
    chk({bufShareA, modeA}, {1'b0, MODE_ASYNC_FIFO});
    // channel B moved data before the load: its pins follow the pin register
    boot(8'h05, 8'h08, 1'b1);
    seed = lfsr(seed);
    bus(1'b1, `DCM_OFS_PINSET, {16'h0, seed});
    @(posedge clk);
    #1;
    chk({chbDataOut, chbDataOeN}, {seed[7:0], ~seed[15:8]});
    rd(`DCM_OFS_PINSET, {16'h0, seed});
    rd(`DCM_OFS_STATUS, 32'h0111);
    rd(4'h2, 32'h0);
    repeat (2) @(posedge clk);
    chk(expQ.size(), 0);
    complete_run();
  end
endmodule : tb_top

// ### design/dcm_chan_mode.sv
// Purpose: mode register of one channel, loaded from eeprom and steered by commands
// Assumes: loadBase and cmdValid never share a cycle
// Notes:   refused is a one-cycle pulse from a flop
`timescale 1ns/1ps
`include "dcm_regs.svh"
module dcm_chan_mode
  import dcm_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              loadBase,
  input  wire dcm_pkg::dcm_mode_e baseIn,
  input  wire logic              cmdValid,
  input  wire logic [7:0]        cmdValue,
  input  wire logic              syncAllowed,
  output dcm_pkg::dcm_mode_e     mode,
  output dcm_pkg::dcm_mode_e     baseMode,
  output logic                   refused
);

  dcm_mode_e mode_reg, mode_next, base_reg, base_next;
  logic      refused_reg, refused_next;

  // ----------------------------------------------------------------------
  // next mode
  // ----------------------------------------------------------------------
  always_comb
  begin
    mode_next    = mode_reg;  // held until reset, eeprom load or own command
    base_next    = base_reg;
    refused_next = 1'b0;
    if (loadBase)
    begin
      mode_next = baseIn;     // eeprom decides the power-up mode
      base_next = baseIn;
    end
    else if (cmdValid)
    begin
      case (cmdValue)
        `DCM_VAL_BASE:     mode_next = base_reg;
        `DCM_VAL_ASYNC_BB: mode_next = MODE_ASYNC_BB;
        `DCM_VAL_SYNC_BB:  mode_next = MODE_SYNC_BB;
        `DCM_VAL_ENGINE:   mode_next = MODE_ENGINE;
        `DCM_VAL_SYNC_FIFO:
        begin
          // only from the both-channels async fifo start
          if (base_reg == MODE_ASYNC_FIFO && syncAllowed)
            mode_next = MODE_SYNC_FIFO;
          else
          begin
            if (base_reg == MODE_ASYNC_FIFO)
              mode_next = MODE_ASYNC_FIFO;
            refused_next = 1'b1;
          end
        end
        default: refused_next = 1'b1;
      endcase
    end
  end

  // any reset brings the channel up as async serial
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mode_reg    <= MODE_ASYNC_SERIAL;
      base_reg    <= MODE_ASYNC_SERIAL;
      refused_reg <= 1'b0;
    end
    else
    begin
      mode_reg    <= mode_next;
      base_reg    <= base_next;
      refused_reg <= refused_next;
    end
  end

  assign mode     = mode_reg;
  assign baseMode = base_reg;
  assign refused  = refused_reg;

endmodule : dcm_chan_mode

// ### design/dcm_mode_select.sv
// Purpose: power-up and commanded mode selection for both channels of the bridge
// Assumes: eeprom data is stable while eeAckIn is high; host pin-sets channel B first
// Notes:   every bus access takes two cycles; writes stall until the eeprom is loaded
`timescale 1ns/1ps
`include "dcm_regs.svh"
module dcm_mode_select
  import dcm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // configuration eeprom fetch
  output logic             eeReq,
  input  wire logic        eeAckIn,
  input  wire logic [7:0]  eeDataIn,
  // channel B activity pin
  input  wire logic        chbTrafficIn,
  // channel state
  output dcm_pkg::dcm_mode_e modeA,
  output dcm_pkg::dcm_mode_e modeB,
  output logic             bufShareA,
  output logic             chbAvailable,
  // channel B pins
  output logic [7:0]       chbDataOut,
  output logic [7:0]       chbDataOeN,
  output logic             chbPullUpEn,
  output logic             tx_space_flag_n,
  output logic             rx_data_flag_n,
  output logic             chbStrobeOeN
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [9:0] syncA_reg, syncB_reg;
  logic       ackSync, trafficSync;
  logic [7:0] dataSync;

  // first stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      syncA_reg <= 10'h000;
      syncB_reg <= 10'h000;
    end
    else
    begin
      syncA_reg <= {chbTrafficIn, eeAckIn, eeDataIn};
      syncB_reg <= syncA_reg;
    end
  end
  assign {trafficSync, ackSync, dataSync} = syncB_reg;

  // eeprom two-bit field to one of the four stored modes
  function automatic dcm_mode_e eeField(input logic [1:0] f);
    eeField = dcm_mode_e'({1'b0, f});
  endfunction : eeField

  // ----------------------------------------------------------------------
  // eeprom loader
  // ----------------------------------------------------------------------
  dcm_load_e  ld_reg, ld_next;
  logic [7:0] eecfg_reg, eecfg_next;
  logic       loadBase;
  logic       ready;

  // four-phase fetch; modes stay async serial until the byte is taken
  always_comb
  begin
    ld_next    = ld_reg;
    eecfg_next = eecfg_reg;
    loadBase   = 1'b0;
    case (ld_reg)
      LD_REQ:
        if (ackSync)
        begin
          eecfg_next = dataSync;
          loadBase   = 1'b1;
          ld_next    = LD_RELEASE;
        end
      LD_RELEASE:
        if (!ackSync)
          ld_next = LD_READY;
      LD_READY: ld_next = LD_READY;
      default:  ld_next = LD_REQ;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ld_reg    <= LD_REQ;
      eecfg_reg <= `DCM_RST_EECFG;
    end
    else
    begin
      ld_reg    <= ld_next;
      eecfg_reg <= eecfg_next;
    end
  end
  assign eeReq = (ld_reg == LD_REQ);
  assign ready = (ld_reg == LD_READY);

  // ----------------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------------
  logic        phase_reg, phase_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [8:0]  cmd_reg, cmd_next;
  logic [15:0] pinset_reg, pinset_next;
  logic        refuse_reg, refuse_next;
  logic        wrDone, cmdWr, cmdValidA, cmdValidB;
  logic        refusedA, refusedB, refusedBusy;
  logic        chbUsed_reg, chbUsed_next, chbDeflt_reg, chbDeflt_next;
  dcm_mode_e   baseA, baseB;

  // commands wait for the loader, so they always follow enumeration
  assign avs_waitrequest = (avs_read | avs_write) & (~phase_reg | (avs_write & ~ready));
  assign wrDone    = avs_write & phase_reg & ready;
  assign cmdWr     = wrDone & (avs_address == `DCM_OFS_CMD) & (&avs_byteenable[1:0]);
  assign cmdValidA = cmdWr & ~avs_writedata[`DCM_CMD_CHAN_BIT];
  // channel B takes no command while lent to channel A
  assign cmdValidB   = cmdWr & avs_writedata[`DCM_CMD_CHAN_BIT] & chbAvailable;
  assign refusedBusy = cmdWr & avs_writedata[`DCM_CMD_CHAN_BIT] & ~chbAvailable;

  always_comb
  begin
    phase_next  = (avs_read | avs_write) & avs_waitrequest;
    cmd_next    = cmdWr ? avs_writedata[8:0] : cmd_reg;
    pinset_next = pinset_reg;
    if (wrDone && avs_address == `DCM_OFS_PINSET)
    begin
      if (avs_byteenable[0])
        pinset_next[7:0] = avs_writedata[7:0];
      if (avs_byteenable[1])
        pinset_next[15:8] = avs_writedata[15:8];
    end
    // sticky refusal: a new refusal wins over the write-one clear
    refuse_next = refuse_reg;
    if (wrDone && avs_address == `DCM_OFS_STATUS && avs_writedata[`DCM_ST_REFUSE_BIT])
      refuse_next = 1'b0;
    if (refusedA | refusedB | refusedBusy)
      refuse_next = 1'b1;
    // channel B traffic is judged at the eeprom load
    chbUsed_next  = chbUsed_reg | trafficSync;
    chbDeflt_next = loadBase ? ~chbUsed_next : chbDeflt_reg;
    // read data latched on the request cycle, shown on the answer cycle
    rdata_next = rdata_reg;
    if (avs_read && !phase_reg)
    begin
      case (avs_address)
        `DCM_OFS_CMD:    rdata_next = {23'h000000, cmd_reg};
        `DCM_OFS_STATUS: rdata_next = {20'h00000, chbDeflt_reg, bufShareA, refuse_reg,
                                       ready, 1'b0, modeB, 1'b0, modeA};
        `DCM_OFS_PINSET: rdata_next = {16'h0000, pinset_reg};
        `DCM_OFS_EECFG:  rdata_next = {24'h000000, eecfg_reg};
        default:         rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      phase_reg    <= 1'b0;
      rdata_reg    <= 32'h00000000;
      cmd_reg      <= `DCM_RST_CMD;
      pinset_reg   <= `DCM_RST_PINSET;
      refuse_reg   <= 1'b0;
      chbUsed_reg  <= 1'b0;
      chbDeflt_reg <= 1'b1;
    end
    else
    begin
      phase_reg    <= phase_next;
      rdata_reg    <= rdata_next;
      cmd_reg      <= cmd_next;
      pinset_reg   <= pinset_next;
      refuse_reg   <= refuse_next;
      chbUsed_reg  <= chbUsed_next;
      chbDeflt_reg <= chbDeflt_next;
    end
  end
  assign avs_readdata = rdata_reg;

  // ----------------------------------------------------------------------
  // channel mode registers
  // ----------------------------------------------------------------------
  // sync fifo is single channel A, from both channels in async fifo
  dcm_chan_mode u_chan_a (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .loadBase   (loadBase),
    .baseIn     (eeField(eecfg_next[`DCM_EE_A_LSB +: 2])),
    .cmdValid   (cmdValidA),
    .cmdValue   (avs_writedata[7:0]),
    .syncAllowed(baseB == MODE_ASYNC_FIFO && modeB == MODE_ASYNC_FIFO),
    .mode       (modeA),
    .baseMode   (baseA),
    .refused    (refusedA)
  );

  dcm_chan_mode u_chan_b (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .loadBase   (loadBase),
    .baseIn     (eeField(eecfg_next[`DCM_EE_B_LSB +: 2])),
    .cmdValid   (cmdValidB),
    .cmdValue   (avs_writedata[7:0]),
    .syncAllowed(1'b0),
    .mode       (modeB),
    .baseMode   (baseB),
    .refused    (refusedB)
  );

  // ----------------------------------------------------------------------
  // memory sharing and channel B pins
  // ----------------------------------------------------------------------
  // B's buffer goes to A and B stops in sync fifo
  assign bufShareA    = (modeA == MODE_SYNC_FIFO);
  assign chbAvailable = ~bufShareA;

  // unused B keeps pulled-up inputs; else the pin-set value stands
  always_comb
  begin
    if (chbDeflt_reg)
    begin
      chbDataOut      = 8'hff;
      chbDataOeN      = 8'hff;
      chbPullUpEn     = 1'b1;
      tx_space_flag_n = 1'b0;
      rx_data_flag_n  = 1'b1;
      chbStrobeOeN    = 1'b1;
    end
    else
    begin
      chbDataOut      = pinset_reg[7:0];
      chbDataOeN      = ~pinset_reg[15:8];
      chbPullUpEn     = 1'b0;
      tx_space_flag_n = 1'b0;
      rx_data_flag_n  = 1'b1;
      chbStrobeOeN    = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_reset_async_serial: assert property ($past(sys_rst) |->
    modeA == MODE_ASYNC_SERIAL && modeB == MODE_ASYNC_SERIAL)
    else $error("channels not async serial after reset");
  a_load_sets_modes: assert property (loadBase |=>
    modeA == eeField($past(dataSync[1:0])) && modeB == eeField($past(dataSync[3:2])))
    else $error("eeprom modes not applied");
  a_base_four_modes: assert property (ready |->
    !baseA[2] && !baseB[2])
    else $error("stored mode outside four eeprom modes");
  a_cmd_bitbang: assert property (
    cmdValidA && avs_writedata[7:0] == `DCM_VAL_SYNC_BB |=> modeA == MODE_SYNC_BB)
    else $error("sync bit-bang command ignored");
  a_sync_fifo_select: assert property (
    cmdValidA && avs_writedata[7:0] == `DCM_VAL_SYNC_FIFO && baseA == MODE_ASYNC_FIFO
    && baseB == MODE_ASYNC_FIFO && modeB == MODE_ASYNC_FIFO |=> modeA == MODE_SYNC_FIFO)
    else $error("sync fifo not selected");
  a_sync_fifo_guard: assert property ($rose(modeA == MODE_SYNC_FIFO) |->
    $past(baseA) == MODE_ASYNC_FIFO && $past(modeB) == MODE_ASYNC_FIFO)
    else $error("sync fifo entered from wrong state");
  a_chb_lent: assert property (modeA == MODE_SYNC_FIFO && cmdWr && avs_writedata[8] |=>
    $stable(modeB) && refuse_reg)
    else $error("channel B accepted command while lent");
  a_chb_defaults: assert property (chbDeflt_reg && modeA == MODE_SYNC_FIFO |->
    chbDataOeN == 8'hff && chbPullUpEn && !tx_space_flag_n && rx_data_flag_n
    && chbStrobeOeN)
    else $error("channel B pins not at defaults");
  a_mode_hold: assert property (!cmdValidA && !loadBase |=> $stable(modeA))
    else $error("channel A mode changed without cause");

endmodule : dcm_mode_select

// ### design/dcm_pkg.sv
// Purpose: types shared by the channel mode selector
// Assumes: nothing
// Notes:   eeprom field codes follow the enum order of the first four modes
package dcm_pkg;

  // operating mode of one channel
  typedef enum logic [2:0] {
    MODE_ASYNC_SERIAL,
    MODE_ASYNC_FIFO,
    MODE_CPU_FIFO,
    MODE_FAST_SERIAL,
    MODE_ASYNC_BB,
    MODE_SYNC_BB,
    MODE_ENGINE,
    MODE_SYNC_FIFO
  } dcm_mode_e;

  // eeprom loader
  typedef enum logic [1:0] {
    LD_REQ,
    LD_RELEASE,
    LD_READY
  } dcm_load_e;

endpackage : dcm_pkg

// ### design/dcm_regs.svh
// Purpose: offsets, field positions, codes and reset values of the channel mode selector
// Assumes: byte addressed Avalon-MM slave, 32-bit data
// Notes:   definitions only
`ifndef DCM_REGS_SVH
`define DCM_REGS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define DCM_OFS_CMD       4'h0
`define DCM_OFS_STATUS    4'h4
`define DCM_OFS_PINSET    4'h8
`define DCM_OFS_EECFG     4'hc

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define DCM_CMD_CHAN_BIT  8
`define DCM_EE_A_LSB      0
`define DCM_EE_B_LSB      2
`define DCM_ST_A_LSB      0
`define DCM_ST_B_LSB      4
`define DCM_ST_READY_BIT  8
`define DCM_ST_REFUSE_BIT 9
`define DCM_ST_SHARE_BIT  10
`define DCM_ST_DEFLT_BIT  11

// ----------------------------------------------------------------------
// channel mode command values
// ----------------------------------------------------------------------
`define DCM_VAL_BASE      8'h00
`define DCM_VAL_ASYNC_BB  8'h01
`define DCM_VAL_ENGINE    8'h02
`define DCM_VAL_SYNC_BB   8'h04
`define DCM_VAL_SYNC_FIFO 8'h40

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define DCM_RST_PINSET    16'h0000
`define DCM_RST_CMD       9'h000
`define DCM_RST_EECFG     8'h00

`endif
